// >>> rtl/exec_unit.sv
// execution unit for invert, bcd adjust, step, sleep, jump, copy, or, returns and rotates
//
// Summary of operation
// RQ1: invert memory byte to memory or accumulator; only zero flag changes.
// RQ2: bcd adjust adds 6 to low nibble if above 9 or half carry.
// RQ3: bcd adjust adds 6 to high nibble if above 9 or carry; result to memory.
// RQ4: bcd adjust changes only carry, set when decimal sum exceeds 100; the code also sets it at exactly 100 (0xa0).
// RQ5: decrement memory byte to memory or accumulator; zero flag updated.
// RQ6: increment memory byte to memory or accumulator; zero flag updated.
// RQ7: sleep stops execution, gates clock, clears watchdog, sets sleep flag, clears expired flag.
// RQ8: jump loads target into program counter, takes two cycles, no flags.
// RQ9: copies between memory, immediate and accumulator change no flag.
// RQ10: idle op only advances the program counter.
// RQ11: or of accumulator with memory or immediate; only zero flag changes.
// RQ12: subroutine exit reloads pc from stack; load variant also sets accumulator.
// RQ13: interrupt exit reloads pc from stack and sets global interrupt enable.
// RQ14: interrupt pending at interrupt exit is serviced before the main program.
// RQ15: rotate left wraps bit 7 into bit 0; no flags change.
// RQ16: rotate left through carry: old carry to bit 0, bit 7 to carry.
// RQ17: rotate right wraps bit 0 into bit 7; no flags change.
// RQ18: rotate right through carry: old carry to bit 7, bit 0 to carry.
// RQ19: every instruction that loads the program counter takes two cycles.
// RQ20: unlisted flags hold; all other instructions take one cycle; the code holds ready_o low after sleep_enter until wake is seen.
`timescale 1ns/100ps

module exec_unit
   import exec_unit_pkg::*;
(
   // clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // instruction issue
   input  wire logic              cmd_valid_i,
   input  wire cmd_type           cmd_i,
   output logic                   ready_o,
   // return stack
   input  wire logic [PC_W-1:0]   stack_top_i,
   output logic                   stack_pop_o,
   output logic                   stack_push_o,
   output logic [PC_W-1:0]        stack_push_addr_o,
   // interrupt and wake
   input  wire logic              irq_pending_i,
   input  wire logic              wake_i,
   output logic                   irq_take_o,
   output logic                   global_irq_enable_o,
   // watchdog
   input  wire logic              dog_timeout_i,
   output logic                   watchdog_counter_clear_o,
   output logic                   dog_expired_flag_o,
   output logic                   sleep_entered_flag_o,
   output logic                   clk_gate_o,
   // data memory write
   output logic                   mem_we_o,
   output logic [7:0]             mem_addr_o,
   output logic [DATA_W-1:0]      mem_wdata_o,
   // architectural state
   output logic [DATA_W-1:0]      acc_o,
   output flags_type              flags_o,
   output logic [PC_W-1:0]        pc_o
);

   state_type          state;
   state_type          next_state;
   logic [DATA_W-1:0]  acc;
   flags_type          flags;
   logic [PC_W-1:0]    pc;
   logic [2:0]         wake_sync;
   logic               wake_seen;
   logic               take;

   // datapath results
   logic [DATA_W-1:0]  next_result;
   logic               next_to_acc;
   logic               next_to_mem;
   logic               next_zero_upd;
   logic               next_carry_upd;
   logic               next_carry;
   logic [DATA_W-1:0]  bcd_fix;
   logic [DATA_W:0]    bcd_sum;
   logic               fix_low;
   logic               fix_high;
   logic               pc_load;
   logic [PC_W-1:0]    next_pc;

   assign take = cmd_valid_i && (state == st_run);

   // wake pin: counted once second and third stage are both high
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wake_sync <= 3'b000;
      end else begin
         wake_sync <= {wake_sync[1:0], wake_i};
      end
   end

   assign wake_seen = wake_sync[1] && wake_sync[2];

   // bcd correction selection
   always_comb begin
      // RQ2 low nibble fix
      fix_low = (acc[3:0] > BCD_DIGIT_MAX) || flags.half_carry;
      // RQ3 high nibble fix
      fix_high = (acc[7:4] > BCD_DIGIT_MAX) || flags.carry;
      case ({fix_high, fix_low})
         2'b01:   bcd_fix = BCD_FIX_LOW;
         2'b10:   bcd_fix = BCD_FIX_HIGH;
         2'b11:   bcd_fix = BCD_FIX_BOTH;
         default: bcd_fix = BCD_FIX_NONE;
      endcase
      bcd_sum = {1'b0, acc} + {1'b0, bcd_fix};
   end

   // operation decode and result
   always_comb begin
      next_result    = cmd_i.mem_data;
      next_to_acc    = 1'b0;
      next_to_mem    = 1'b0;
      next_zero_upd  = 1'b0;
      next_carry_upd = 1'b0;
      next_carry     = flags.carry;
      case (cmd_i.op)
         // RQ1 invert memory byte
         invert_in_memory, invert_in_acc: begin
            next_result   = ~cmd_i.mem_data;
            next_to_mem   = (cmd_i.op == invert_in_memory);
            next_to_acc   = (cmd_i.op == invert_in_acc);
            next_zero_upd = 1'b1;
         end
         // RQ3 adjusted value to memory
         bcd_adjust: begin
            next_result    = bcd_sum[DATA_W-1:0];
            next_to_mem    = 1'b1;
            next_carry_upd = 1'b1;
            // RQ4 carry chains decimal sums
            next_carry     = flags.carry || fix_high || bcd_sum[DATA_W];
         end
         // RQ5 decrement
         minus_one_in_memory, minus_one_in_acc: begin
            next_result   = cmd_i.mem_data - ONE_BYTE;
            next_to_mem   = (cmd_i.op == minus_one_in_memory);
            next_to_acc   = (cmd_i.op == minus_one_in_acc);
            next_zero_upd = 1'b1;
         end
         // RQ6 increment
         plus_one_in_memory, plus_one_in_acc: begin
            next_result   = cmd_i.mem_data + ONE_BYTE;
            next_to_mem   = (cmd_i.op == plus_one_in_memory);
            next_to_acc   = (cmd_i.op == plus_one_in_acc);
            next_zero_upd = 1'b1;
         end
         // RQ9 flagless copies
         copy_mem_to_acc: begin
            next_to_acc = 1'b1;
         end
         copy_imm_to_acc: begin
            next_result = cmd_i.imm;
            next_to_acc = 1'b1;
         end
         copy_acc_to_mem: begin
            next_result = acc;
            next_to_mem = 1'b1;
         end
         // RQ11 bitwise or
         disjunction_mem_acc: begin
            next_result   = acc | cmd_i.mem_data;
            next_to_acc   = 1'b1;
            next_zero_upd = 1'b1;
         end
         disjunction_imm_acc: begin
            next_result   = acc | cmd_i.imm;
            next_to_acc   = 1'b1;
            next_zero_upd = 1'b1;
         end
         disjunction_in_memory: begin
            next_result   = acc | cmd_i.mem_data;
            next_to_mem   = 1'b1;
            next_zero_upd = 1'b1;
         end
         // RQ12 load variant sets accumulator
         sub_exit_load: begin
            next_result = cmd_i.imm;
            next_to_acc = 1'b1;
         end
         // RQ15 plain rotate left
         rotate_left_mem, rotate_left_acc: begin
            next_result = {cmd_i.mem_data[6:0], cmd_i.mem_data[7]};
            next_to_mem = (cmd_i.op == rotate_left_mem);
            next_to_acc = (cmd_i.op == rotate_left_acc);
         end
         // RQ16 rotate left through carry
         rotate_left_carry_mem, rotate_left_carry_acc: begin
            next_result    = {cmd_i.mem_data[6:0], flags.carry};
            next_to_mem    = (cmd_i.op == rotate_left_carry_mem);
            next_to_acc    = (cmd_i.op == rotate_left_carry_acc);
            next_carry_upd = 1'b1;
            next_carry     = cmd_i.mem_data[7];
         end
         // RQ17 plain rotate right
         rotate_right_mem, rotate_right_acc: begin
            next_result = {cmd_i.mem_data[0], cmd_i.mem_data[7:1]};
            next_to_mem = (cmd_i.op == rotate_right_mem);
            next_to_acc = (cmd_i.op == rotate_right_acc);
         end
         // RQ18 rotate right through carry
         rotate_right_carry_mem, rotate_right_carry_acc: begin
            next_result    = {flags.carry, cmd_i.mem_data[7:1]};
            next_to_mem    = (cmd_i.op == rotate_right_carry_mem);
            next_to_acc    = (cmd_i.op == rotate_right_carry_acc);
            next_carry_upd = 1'b1;
            next_carry     = cmd_i.mem_data[0];
         end
         default: next_result = cmd_i.mem_data;
      endcase
   end

   // program counter source
   always_comb begin
      pc_load = 1'b1;
      case (cmd_i.op)
         // RQ8 jump target
         jump_absolute: next_pc = cmd_i.target;
         // RQ12 return address from stack
         sub_exit:      next_pc = stack_top_i;
         sub_exit_load: next_pc = stack_top_i;
         // RQ14 pending interrupt goes first
         irq_exit:      next_pc = irq_pending_i ? IRQ_VECTOR : stack_top_i;
         default: begin
            // RQ10 plain advance
            pc_load = 1'b0;
            next_pc = pc + PC_STEP;
         end
      endcase
   end

   // sequencing
   always_comb begin
      next_state = state;
      case (state)
         st_run: begin
            if (take && cmd_i.op == sleep_enter) begin
               next_state = st_sleep;
            // RQ19 dummy slot on pc load
            end else if (take && pc_load) begin
               next_state = st_dummy;
            end
         end
         // RQ20 single dummy cycle only
         st_dummy: next_state = st_run;
         st_sleep: begin
            if (wake_seen) begin
               next_state = st_run;
            end
         end
         default: next_state = st_run;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state   <= st_run;
         ready_o <= 1'b1;
      end else begin
         state   <= next_state;
         ready_o <= (next_state == st_run);
      end
   end

   // accumulator and flags; unlisted flags hold
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acc   <= ACC_RESET;
         flags <= FLAGS_RESET;
      end else if (take) begin
         if (next_to_acc) begin
            acc <= next_result;
         end
         // RQ20 only listed flags change
         if (next_zero_upd) begin
            flags.zero <= (next_result == '0);
         end
         if (next_carry_upd) begin
            flags.carry <= next_carry;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pc <= PC_RESET;
      end else if (take) begin
         pc <= next_pc;
      end
   end

   // memory write port, one-cycle strobe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mem_we_o    <= 1'b0;
         mem_addr_o  <= 8'h00;
         mem_wdata_o <= 8'h00;
      end else begin
         mem_we_o <= take && next_to_mem;
         if (take && next_to_mem) begin
            mem_addr_o  <= cmd_i.mem_addr;
            mem_wdata_o <= next_result;
         end
      end
   end

   // stack and interrupt handoff
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         stack_pop_o         <= 1'b0;
         stack_push_o        <= 1'b0;
         stack_push_addr_o   <= PC_RESET;
         irq_take_o          <= 1'b0;
         global_irq_enable_o <= 1'b0;
      end else begin
         stack_pop_o  <= take && (cmd_i.op == sub_exit || cmd_i.op == sub_exit_load ||
                                  cmd_i.op == irq_exit);
         // RQ14 re-push return address for the pending routine
         stack_push_o <= take && cmd_i.op == irq_exit && irq_pending_i;
         irq_take_o   <= take && cmd_i.op == irq_exit && irq_pending_i;
         if (take && cmd_i.op == irq_exit) begin
            stack_push_addr_o <= stack_top_i;
            // RQ13 enable set; written clear instead when a pending routine is entered
            global_irq_enable_o <= !irq_pending_i;
         end
      end
   end

   // sleep entry and watchdog status
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         watchdog_counter_clear_o <= 1'b0;
         sleep_entered_flag_o     <= 1'b0;
         dog_expired_flag_o       <= 1'b0;
         clk_gate_o               <= 1'b0;
      end else begin
         watchdog_counter_clear_o <= take && cmd_i.op == sleep_enter;
         // RQ7 flags, clock gate and watchdog clear
         if (take && cmd_i.op == sleep_enter) begin
            sleep_entered_flag_o <= 1'b1;
            clk_gate_o           <= 1'b1;
         end else if (state == st_sleep && wake_seen) begin
            clk_gate_o <= 1'b0;
         end
         // timeout set wins over the sleep clear
         if (dog_timeout_i) begin
            dog_expired_flag_o <= 1'b1;
         end else if (take && cmd_i.op == sleep_enter) begin
            dog_expired_flag_o <= 1'b0;
         end
      end
   end

   assign acc_o   = acc;
   assign flags_o = flags;
   assign pc_o    = pc;

endmodule // exec_unit

// >>> rtl/exec_unit_pkg.sv
// package: opcodes, command carrier and constants of the execution unit
package exec_unit_pkg;

   localparam int DATA_W = 8;
   localparam int PC_W   = 12;

   // opcode of one issued instruction
   typedef enum logic [4:0] {
      idle_op               = 5'h00,
      invert_in_memory      = 5'h01,
      invert_in_acc         = 5'h02,
      bcd_adjust            = 5'h03,
      minus_one_in_memory   = 5'h04,
      minus_one_in_acc      = 5'h05,
      plus_one_in_memory    = 5'h06,
      plus_one_in_acc       = 5'h07,
      sleep_enter           = 5'h08,
      jump_absolute         = 5'h09,
      copy_mem_to_acc       = 5'h0a,
      copy_imm_to_acc       = 5'h0b,
      copy_acc_to_mem       = 5'h0c,
      disjunction_mem_acc   = 5'h0d,
      disjunction_imm_acc   = 5'h0e,
      disjunction_in_memory = 5'h0f,
      sub_exit              = 5'h10,
      sub_exit_load         = 5'h11,
      irq_exit              = 5'h12,
      rotate_left_mem       = 5'h13,
      rotate_left_acc       = 5'h14,
      rotate_left_carry_mem = 5'h15,
      rotate_left_carry_acc = 5'h16,
      rotate_right_mem      = 5'h17,
      rotate_right_acc      = 5'h18,
      rotate_right_carry_mem = 5'h19,
      rotate_right_carry_acc = 5'h1a
   } opcode_type;

   // one issued instruction with its fetched operands
   typedef struct packed {
      opcode_type          op;
      logic [7:0]          mem_addr;
      logic [DATA_W-1:0]   mem_data;
      logic [DATA_W-1:0]   imm;
      logic [PC_W-1:0]     target;
   } cmd_type;

   // arithmetic flags
   typedef struct packed {
      logic zero;
      logic carry;
      logic half_carry;
   } flags_type;

   typedef enum logic [1:0] {
      st_run   = 2'b00,
      st_dummy = 2'b01,
      st_sleep = 2'b10
   } state_type;

   localparam logic [DATA_W-1:0] ACC_RESET      = 8'h00;
   localparam flags_type         FLAGS_RESET    = '0;
   localparam logic [PC_W-1:0]   PC_RESET       = 12'h000;
   localparam logic [PC_W-1:0]   PC_STEP        = 12'h001;
   localparam logic [PC_W-1:0]   IRQ_VECTOR     = 12'h004;
   localparam logic [DATA_W-1:0] ONE_BYTE       = 8'h01;
   localparam logic [3:0]        BCD_DIGIT_MAX  = 4'h9;
   localparam logic [DATA_W-1:0] BCD_FIX_NONE   = 8'h00;
   localparam logic [DATA_W-1:0] BCD_FIX_LOW    = 8'h06;
   localparam logic [DATA_W-1:0] BCD_FIX_HIGH   = 8'h60;
   localparam logic [DATA_W-1:0] BCD_FIX_BOTH   = 8'h66;
   localparam int                DUMMY_CYCLES   = 1;

endpackage : exec_unit_pkg

// >>> dv/exec_unit_properties.sv
// checker: result and timing properties of the execution unit
`timescale 1ns/100ps

module exec_unit_properties
   import exec_unit_pkg::*;
(
   // clock and reset
   input wire logic            mclk_i,
   input wire logic            rst_i,
   // issue side
   input wire logic            cmd_valid_i,
   input wire cmd_type         cmd_i,
   input wire logic [PC_W-1:0] stack_top_i,
   input wire logic            irq_pending_i,
   input wire logic            dog_timeout_i,
   // results
   input wire logic            ready_o,
   input wire logic            stack_pop_o,
   input wire logic [PC_W-1:0] stack_push_addr_o,
   input wire logic            irq_take_o,
   input wire logic            global_irq_enable_o,
   input wire logic            watchdog_counter_clear_o,
   input wire logic            dog_expired_flag_o,
   input wire logic            sleep_entered_flag_o,
   input wire logic            clk_gate_o,
   input wire logic            mem_we_o,
   input wire logic [7:0]      mem_wdata_o,
   input wire logic [7:0]      acc_o,
   input wire flags_type       flags_o,
   input wire logic [PC_W-1:0] pc_o
);
   logic       take;
   logic [7:0] prev_mem;

   assign take = cmd_valid_i && ready_o;

   // operand one cycle back, so bit slices need no $past
   always_ff @(posedge mclk_i) begin
      prev_mem <= cmd_i.mem_data;
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_take(opcode_type o);
      take && cmd_i.op == o;
   endsequence

   // pc loads refuse one cycle, then accept again
   sequence s_gap;
      !ready_o ##1 ready_o;
   endsequence

   a_jump_target: assert property (
      s_take(jump_absolute) |=> (pc_o == $past(cmd_i.target) && flags_o == $past(flags_o)) ##0 s_gap)
      else $error("jump target or gap wrong");
   a_sub_exit_load: assert property (
      s_take(sub_exit_load) |=> (pc_o == $past(stack_top_i) && acc_o == $past(cmd_i.imm) && stack_pop_o) ##0 s_gap)
      else $error("return with load wrong");
   a_inc_memory: assert property (
      s_take(plus_one_in_memory) |=> mem_we_o && mem_wdata_o == $past(cmd_i.mem_data) + ONE_BYTE
         && flags_o.zero == (mem_wdata_o == 8'h00))
      else $error("increment to memory wrong");
   a_invert_memory: assert property (
      s_take(invert_in_memory) |=> mem_wdata_o == ~prev_mem && flags_o.carry == $past(flags_o.carry))
      else $error("invert to memory wrong");
   a_copy_flags_kept: assert property (
      take && cmd_i.op inside {copy_mem_to_acc, copy_imm_to_acc, copy_acc_to_mem, idle_op}
         |=> flags_o == $past(flags_o))
      else $error("copy or idle changed flags");
   a_sleep_entry: assert property (
      s_take(sleep_enter) ##0 !dog_timeout_i |=> clk_gate_o && sleep_entered_flag_o
         && !dog_expired_flag_o && watchdog_counter_clear_o && !ready_o)
      else $error("sleep entry wrong");
   a_irq_exit_plain: assert property (
      s_take(irq_exit) ##0 !irq_pending_i |=> (global_irq_enable_o && pc_o == $past(stack_top_i)) ##0 s_gap)
      else $error("interrupt return wrong");
   a_irq_exit_pending: assert property (
      s_take(irq_exit) ##0 irq_pending_i |=> irq_take_o && pc_o == IRQ_VECTOR
         && stack_push_addr_o == $past(stack_top_i))
      else $error("pending interrupt not taken");
   a_rrc_carry: assert property (
      s_take(rotate_right_carry_mem) |=> mem_wdata_o == {$past(flags_o.carry), prev_mem[7:1]}
         && flags_o.carry == prev_mem[0])
      else $error("rotate right through carry wrong");
   a_one_cycle_ops: assert property (
      take && !(cmd_i.op inside {jump_absolute, sub_exit, sub_exit_load, irq_exit, sleep_enter})
         |=> ready_o && pc_o == $past(pc_o) + PC_STEP)
      else $error("single cycle op stalled or pc wrong");
endmodule // exec_unit_properties

bind exec_unit exec_unit_properties u_props (
   .mclk_i, .rst_i, .cmd_valid_i, .cmd_i, .stack_top_i, .irq_pending_i, .dog_timeout_i,
   .ready_o, .stack_pop_o, .stack_push_addr_o, .irq_take_o, .global_irq_enable_o,
   .watchdog_counter_clear_o, .dog_expired_flag_o, .sleep_entered_flag_o, .clk_gate_o,
   .mem_we_o, .mem_wdata_o, .acc_o, .flags_o, .pc_o
);

// >>> dv/tb_top.sv
// testbench: row table and hand-written cases for the execution unit
`timescale 1ns/100ps

module tb_top
   import exec_unit_pkg::*;
();
   typedef struct packed {
      opcode_type op;
      logic [7:0] mem;
      logic [7:0] imm;
      logic [7:0] acc;
      logic       we;
      logic [7:0] wdat;
      flags_type  flg;
   } row_type;
   localparam int NROWS = 29;

   logic            mclk_i, rst_i, cmd_valid_i, irq_pending_i, wake_i, dog_timeout_i;
   cmd_type         cmd_i;
   logic [PC_W-1:0] stack_top_i, stack_push_addr_o, pc_o, exp_pc;
   logic            ready_o, stack_pop_o, stack_push_o, irq_take_o, global_irq_enable_o;
   logic            watchdog_counter_clear_o, dog_expired_flag_o, sleep_entered_flag_o;
   logic            clk_gate_o, mem_we_o;
   logic [7:0]      mem_addr_o, mem_wdata_o, acc_o;
   flags_type       flags_o;
   row_type         r;
   int              errors, checks_done, n;
   // back-to-back rows: results carry from one row to the next
   row_type rows [NROWS] = '{
      '{copy_imm_to_acc,8'h55,8'h00,8'h00,1'b0,8'h00,3'h0}, '{copy_mem_to_acc,8'h3c,8'hc3,8'h3c,1'b0,8'h00,3'h0},
      '{disjunction_imm_acc,8'h02,8'h41,8'h7d,1'b0,8'h00,3'h0}, '{invert_in_acc,8'hff,8'h00,8'h00,1'b0,8'h00,3'h4},
      '{disjunction_mem_acc,8'h00,8'hff,8'h00,1'b0,8'h00,3'h4}, '{plus_one_in_acc,8'hff,8'h00,8'h00,1'b0,8'h00,3'h4},
      '{plus_one_in_memory,8'h7f,8'h00,8'h00,1'b1,8'h80,3'h0}, '{minus_one_in_memory,8'h01,8'h00,8'h00,1'b1,8'h00,3'h4},
      '{minus_one_in_acc,8'h00,8'h00,8'hff,1'b0,8'h00,3'h0}, '{invert_in_memory,8'ha5,8'h00,8'hff,1'b1,8'h5a,3'h0},
      '{copy_acc_to_mem,8'h12,8'h00,8'hff,1'b1,8'hff,3'h0}, '{disjunction_in_memory,8'h00,8'h00,8'hff,1'b1,8'hff,3'h0},
      '{rotate_left_carry_acc,8'h81,8'h00,8'h02,1'b0,8'h00,3'h2}, '{rotate_left_acc,8'h81,8'h00,8'h03,1'b0,8'h00,3'h2},
      '{rotate_right_carry_mem,8'h02,8'h00,8'h03,1'b1,8'h81,3'h0}, '{rotate_right_acc,8'h01,8'h00,8'h80,1'b0,8'h00,3'h0},
      '{rotate_left_mem,8'h80,8'h00,8'h80,1'b1,8'h01,3'h0}, '{rotate_right_mem,8'h01,8'h00,8'h80,1'b1,8'h80,3'h0},
      '{rotate_left_carry_mem,8'h80,8'h00,8'h80,1'b1,8'h00,3'h2}, '{rotate_right_carry_acc,8'h00,8'h00,8'h80,1'b0,8'h00,3'h0},
      '{idle_op,8'h00,8'h00,8'h80,1'b0,8'h00,3'h0}, '{copy_imm_to_acc,8'h00,8'h45,8'h45,1'b0,8'h00,3'h0},
      '{bcd_adjust,8'h00,8'h00,8'h45,1'b1,8'h45,3'h0}, '{copy_imm_to_acc,8'h00,8'h5b,8'h5b,1'b0,8'h00,3'h0},
      '{bcd_adjust,8'h00,8'h00,8'h5b,1'b1,8'h61,3'h0}, '{copy_imm_to_acc,8'h00,8'ha3,8'ha3,1'b0,8'h00,3'h0},
      '{bcd_adjust,8'h00,8'h00,8'ha3,1'b1,8'h03,3'h2}, '{copy_imm_to_acc,8'h00,8'h2b,8'h2b,1'b0,8'h00,3'h2},
      '{bcd_adjust,8'h00,8'h00,8'h2b,1'b1,8'h91,3'h2}};

   exec_unit DUT (
      .mclk_i, .rst_i, .cmd_valid_i, .cmd_i, .ready_o, .stack_top_i, .stack_pop_o, .stack_push_o,
      .stack_push_addr_o, .irq_pending_i, .wake_i, .irq_take_o, .global_irq_enable_o, .dog_timeout_i,
      .watchdog_counter_clear_o, .dog_expired_flag_o, .sleep_entered_flag_o, .clk_gate_o,
      .mem_we_o, .mem_addr_o, .mem_wdata_o, .acc_o, .flags_o, .pc_o
   );

   always #20 mclk_i = ~mclk_i;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // called just after a rising edge; NBA keeps the edge race-free
   task automatic issue(input opcode_type op, input logic [7:0] m, input logic [7:0] x,
                        input logic [PC_W-1:0] t);
      cmd_valid_i <= 1'b1;
      cmd_i       <= '{op: op, mem_addr: 8'h3a, mem_data: m, imm: x, target: t};
   endtask

   task automatic one(input opcode_type op, input logic [7:0] x, input logic [PC_W-1:0] top);
      @(posedge mclk_i);
      issue(op, 8'h00, x, 12'h000);
      stack_top_i <= top;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      @(negedge mclk_i);
   endtask

   initial begin
      {mclk_i, cmd_valid_i, irq_pending_i, wake_i, dog_timeout_i} = '0;
      rst_i = 1'b1;
      cmd_i = '0;
      stack_top_i = 12'h000;
      {errors, checks_done} = '0;
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      exp_pc = PC_RESET;
      for (int i = 0; i <= NROWS; i++) begin
         @(posedge mclk_i);
         if (i < NROWS) issue(rows[i].op, rows[i].mem, rows[i].imm, 12'h000);
         else cmd_valid_i <= 1'b0;
         if (i > 0) begin
            @(negedge mclk_i);
            r = rows[i-1];
            exp_pc = exp_pc + PC_STEP;
            check(acc_o, r.acc);
            check(flags_o, r.flg);
            check(mem_we_o, r.we);
            if (r.we) check({mem_addr_o, mem_wdata_o}, {8'h3a, r.wdat});
            check(pc_o, exp_pc);
         end
      end
      $display("test rows done");
      @(posedge mclk_i);
      dog_timeout_i <= 1'b1;
      @(posedge mclk_i);
      dog_timeout_i <= 1'b0;
      @(negedge mclk_i);
      check(dog_expired_flag_o, 1'b1);
      one(sleep_enter, 8'h00, 12'h000);
      check({clk_gate_o, sleep_entered_flag_o, dog_expired_flag_o, ready_o, watchdog_counter_clear_o}, 5'h19);
      check(acc_o, 8'h2b);
      // sleep entry still steps the program counter
      exp_pc = exp_pc + PC_STEP;
      check(pc_o, exp_pc);
      @(posedge mclk_i);
      wake_i <= 1'b1;
      n = 0;
      while (ready_o !== 1'b1 && n < 10) begin
         @(negedge mclk_i);
         n++;
      end
      if (n == 10) begin
         errors++;
         finish_test();
      end
      check(clk_gate_o, 1'b0);
      @(posedge mclk_i);
      wake_i <= 1'b0;
      $display("test sleep done");
      // jump, then a held request is refused for one cycle
      @(posedge mclk_i);
      issue(jump_absolute, 8'h00, 8'h00, 12'h5a5);
      @(posedge mclk_i);
      issue(idle_op, 8'h00, 8'h00, 12'h000);
      @(negedge mclk_i);
      check({ready_o, flags_o, pc_o}, 16'h2_5a5);
      @(negedge mclk_i);
      check(pc_o, 12'h5a5);
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      @(negedge mclk_i);
      check(pc_o, 12'h5a6);
      $display("test jump done");
      one(sub_exit_load, 8'h77, 12'h123);
      check({stack_pop_o, acc_o, pc_o}, 24'h17_7123);
      one(sub_exit, 8'h00, 12'h234);
      check(pc_o, 12'h234);
      one(irq_exit, 8'h00, 12'h345);
      check({global_irq_enable_o, irq_take_o, stack_push_o, pc_o}, 16'h4345);
      @(posedge mclk_i);
      irq_pending_i <= 1'b1;
      one(irq_exit, 8'h00, 12'h456);
      check({irq_take_o, stack_push_o, global_irq_enable_o, pc_o}, {3'b110, IRQ_VECTOR});
      check(stack_push_addr_o, 12'h456);
      @(posedge mclk_i);
      irq_pending_i <= 1'b0;
      $display("test returns done");
      @(posedge mclk_i);
      rst_i <= 1'b1;
      @(negedge mclk_i);
      @(negedge mclk_i);
      check({ready_o, global_irq_enable_o, acc_o, flags_o, pc_o}, {1'b1, 1'b0, 8'h00, 3'h0, 12'h000});
      @(posedge mclk_i);
      rst_i <= 1'b0;
      $display("test reset done");
      finish_test();
   end

   initial begin
      repeat (5000) @(posedge mclk_i);
      errors++;
      finish_test();
   end
endmodule // tb_top
